// ==== rtl/crsrc_regs.svh ====
// Offsets, field positions, reset values and timing counts of the slave record controller.
`ifndef CRSRC_REGS_SVH
`define CRSRC_REGS_SVH
`define CRSRC_ADDR_CTRL 12'h000
`define CRSRC_ADDR_SRCSEL 12'h004
`define CRSRC_ADDR_ARM 12'h008
`define CRSRC_ADDR_STATUS 12'h00C
`define CRSRC_ADDR_ROUTE 12'h010
`define CRSRC_CTRL_FMT_ARM 0
`define CRSRC_CTRL_DIG_SEL 1
`define CRSRC_CTRL_FP_SRC 2
`define CRSRC_SRCSEL_RST 8'hFF
`define CRSRC_FLASH_HALF_MS 250
`define CRSRC_CLK_MHZ 25
`define CRSRC_FLASH_CYC (`CRSRC_FLASH_HALF_MS * 1000 * `CRSRC_CLK_MHZ)
`define CRSRC_LOSS_CYC 32
`endif

// ==== rtl/crsrc_pkg.sv ====
// Types shared by the slave record controller.
package crsrc_pkg;
  typedef enum logic [2:0] {
    CRSRC_IDLE = 3'b000,
    CRSRC_REWIND = 3'b001,
    CRSRC_LOCATE = 3'b011,
    CRSRC_CHASE = 3'b010,
    CRSRC_RUN = 3'b110
  } crsrc_state_e;
  typedef enum logic [1:0] {
    CRSRC_CMD_FULL = 2'h0,
    CRSRC_CMD_EXTEND = 2'h1,
    CRSRC_CMD_RECORD = 2'h2
  } crsrc_cmd_e;
  typedef struct packed {
    logic go;
    crsrc_cmd_e cmd;
    logic at_start;
    logic stop;
  } crsrc_master_s;
  typedef struct packed {
    logic rewind;
    logic locate;
    logic play;
    logic format;
    logic extend;
    logic no_fmt_code;
  } crsrc_xport_s;
  typedef logic [23:0] crsrc_route_t;
endpackage : crsrc_pkg

// ==== rtl/crsrc_router.sv ====
// Cyclic source-channel to armed-track routing map.
`timescale 1ns/100ps
module crsrc_router
  import crsrc_pkg::*;
#(
  parameter int N = 8
) (
  // Selections.
  input wire logic [N-1:0] i_src_sel,
  input wire logic [N-1:0] i_arm,
  // Map: three bits of source per track, plus silence flags.
  output crsrc_route_t o_route,
  output logic [N-1:0] o_silent
);
  function automatic logic [3:0] pop(input logic [N-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < N; k++) begin
      c = c + {3'h0, v[k]};
    end
    return c;
  endfunction : pop

  always_comb begin
    logic [3:0] nsrc;
    logic [3:0] slot;
    logic [3:0] seen;
    nsrc = pop(i_src_sel);
    slot = 4'h0;
    seen = 4'h0;
    o_route = '0;
    o_silent = '0;
    for (int t = 0; t < N; t++) begin
      o_route[t*3 +: 3] = 3'(t);
      if (nsrc == 4'h8) begin
        o_route[t*3 +: 3] = 3'(t);
      end else if (i_arm[t]) begin
        if (nsrc == 4'h0) begin
          o_silent[t] = 1'b1;
        end else begin
          seen = 4'h0;
          for (int s = 0; s < N; s++) begin
            if (i_src_sel[s]) begin
              if (seen == slot) begin
                o_route[t*3 +: 3] = 3'(s);
              end
              seen = seen + 4'h1;
            end
          end
          slot = (slot + 4'h1 == nsrc) ? 4'h0 : slot + 4'h1;
        end
      end
    end
  end
endmodule : crsrc_router

// ==== rtl/crsrc_ctrl.sv ====
// Slave record controller: format response, record gating and digital input routing.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "crsrc_regs.svh"
module crsrc_ctrl
  import crsrc_pkg::*;
#(
  parameter int N = 8,
  parameter int FLASH_CYC = `CRSRC_FLASH_CYC
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Master over sync cable, already in this domain.
  input crsrc_master_s i_master,
  input wire logic i_master_sync,
  // Local transport status.
  input wire logic i_tape_formatted,
  input wire logic i_at_position,
  input wire logic i_sample_lock,
  // Remote routing request.
  input wire logic i_rmt_we,
  input wire logic [N-1:0] i_rmt_src,
  // Optical link from outside the clock domain.
  input wire logic i_opt_clk,
  input wire logic [N-1:0] i_opt_data,
  // Analog record audio, one bit per track.
  input wire logic [N-1:0] i_ana_data,
  // Transport and indicators.
  output crsrc_xport_s o_xport,
  output logic o_fmt_lamp,
  output logic o_dig_lamp,
  output logic o_chase_lamp,
  output logic [N-1:0] o_rec_en,
  output logic [N-1:0] o_source_channel_lamps,
  output logic [N-1:0] o_rec_data
);
  crsrc_state_e state_r;
  crsrc_xport_s plan_r;
  logic fmt_arm_r, dig_sel_r, fp_src_r, no_fmt_r, full_pass_r;
  logic [N-1:0] src_sel_r, arm_r, frz_src_r, frz_arm_r, rec_data_r;
  logic [$clog2(FLASH_CYC+1)-1:0] flash_cnt_r;
  logic flash_r;
  logic [2:0] oclk_sync_r;
  logic [N-1:0] odat_s1_r, odat_s2_r;
  logic [5:0] loss_cnt_r;
  logic opt_present_r;
  crsrc_route_t route;
  logic [N-1:0] silent;
  logic rec_allow;
  logic apb_wr, apb_rd;

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // Register writes; front panel wins over remote on the same cycle.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fmt_arm_r <= 1'b0;
      dig_sel_r <= 1'b0;
      fp_src_r <= 1'b0;
      src_sel_r <= `CRSRC_SRCSEL_RST;
      arm_r <= '0;
    end else begin
      if (i_rmt_we) begin
        src_sel_r <= i_rmt_src;
      end
      if (apb_wr) begin
        unique case (i_paddr)
          `CRSRC_ADDR_CTRL: begin
            fmt_arm_r <= i_pwdata[`CRSRC_CTRL_FMT_ARM];
            dig_sel_r <= i_pwdata[`CRSRC_CTRL_DIG_SEL];
          end
          `CRSRC_ADDR_SRCSEL: begin
            src_sel_r <= i_pwdata[N-1:0];
            fp_src_r <= 1'b1;
          end
          `CRSRC_ADDR_ARM: arm_r <= i_pwdata[N-1:0];
          default: ;
        endcase
      end
    end
  end

  // Read data registered on the setup cycle, valid in the access cycle.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0;
    end else if (apb_rd && !i_penable) begin
      unique case (i_paddr)
        `CRSRC_ADDR_CTRL: o_prdata <= {29'h0, fp_src_r, dig_sel_r, fmt_arm_r};
        `CRSRC_ADDR_SRCSEL: o_prdata <= {24'h0, src_sel_r};
        `CRSRC_ADDR_ARM: o_prdata <= {24'h0, arm_r};
        `CRSRC_ADDR_STATUS:
          o_prdata <= {24'h0, opt_present_r, i_sample_lock, no_fmt_r,
                       full_pass_r, 1'b0, state_r};
        `CRSRC_ADDR_ROUTE: o_prdata <= {8'h0, route};
        default: o_prdata <= 32'h0;
      endcase
    end
  end

  // Response to the master's command selects the plan of motion.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= CRSRC_IDLE;
      plan_r <= '0;
      no_fmt_r <= 1'b0;
      full_pass_r <= 1'b0;
    end else if (i_master.stop) begin
      state_r <= CRSRC_IDLE;
      plan_r <= '0;
      no_fmt_r <= 1'b0;
      full_pass_r <= 1'b0;
    end else begin
      unique case (state_r)
        CRSRC_IDLE: begin
          if (i_master.go) begin
            plan_r <= '0;
            no_fmt_r <= 1'b0;
            full_pass_r <= 1'b0;
            if (i_master.cmd == CRSRC_CMD_FULL ||
                (i_master.cmd == CRSRC_CMD_RECORD && i_master.at_start && fmt_arm_r)) begin
              state_r <= CRSRC_REWIND;
              full_pass_r <= 1'b1;
              if (fmt_arm_r) begin
                plan_r.format <= 1'b1;
              end else if (!i_tape_formatted) begin
                no_fmt_r <= 1'b1;
              end
            end else if (!i_tape_formatted) begin
              state_r <= CRSRC_RUN;
              no_fmt_r <= 1'b1;
            end else begin
              state_r <= CRSRC_LOCATE;
              if (fmt_arm_r) begin
                plan_r.extend <= 1'b1;
              end
            end
          end
        end
        CRSRC_REWIND: begin
          if (i_at_position) begin
            state_r <= CRSRC_CHASE;
          end
        end
        CRSRC_LOCATE: begin
          if (i_at_position) begin
            state_r <= CRSRC_CHASE;
          end
        end
        CRSRC_CHASE: begin
          if (i_sample_lock) begin
            state_r <= CRSRC_RUN;
          end
        end
        CRSRC_RUN: begin
          if (!no_fmt_r && !i_sample_lock) begin
            state_r <= CRSRC_CHASE;
          end
        end
        default: state_r <= CRSRC_IDLE;
      endcase
    end
  end

  // Record enable waits for lock and master sync; arming on the master is not needed.
  assign rec_allow = (state_r == CRSRC_RUN) && !no_fmt_r && i_sample_lock
                     && i_master_sync;

  always_comb begin
    o_xport = '0;
    o_xport.rewind = (state_r == CRSRC_REWIND);
    o_xport.locate = (state_r == CRSRC_LOCATE);
    o_xport.play = (state_r == CRSRC_CHASE) || (state_r == CRSRC_RUN);
    o_xport.format = plan_r.format && rec_allow;
    o_xport.extend = plan_r.extend && rec_allow;
    o_xport.no_fmt_code = no_fmt_r;
    o_rec_en = rec_allow ? frz_arm_r : '0;
    o_chase_lamp = (state_r == CRSRC_CHASE);
    o_fmt_lamp = no_fmt_r ? flash_r : (fmt_arm_r || plan_r.format);
    o_source_channel_lamps = src_sel_r;
  end

  // Routing inputs frozen while recording.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      frz_src_r <= `CRSRC_SRCSEL_RST;
      frz_arm_r <= '0;
    end else if (!rec_allow) begin
      frz_src_r <= src_sel_r;
      frz_arm_r <= arm_r;
    end
  end

  crsrc_router #(.N(N)) u_router (
    .i_src_sel(frz_src_r),
    .i_arm(frz_arm_r),
    .o_route(route),
    .o_silent(silent)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flash_cnt_r <= '0;
      flash_r <= 1'b0;
    end else if (flash_cnt_r == ($bits(flash_cnt_r))'(FLASH_CYC - 1)) begin
      flash_cnt_r <= '0;
      flash_r <= !flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 1'b1;
    end
  end

  // Optical link sampled through two flip-flops; a third stage finds edges.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      oclk_sync_r <= '0;
      odat_s1_r <= '0;
      odat_s2_r <= '0;
    end else begin
      oclk_sync_r <= {oclk_sync_r[1:0], i_opt_clk};
      odat_s1_r <= i_opt_data;
      odat_s2_r <= odat_s1_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      loss_cnt_r <= '0;
      opt_present_r <= 1'b0;
    end else if (oclk_sync_r[2] != oclk_sync_r[1]) begin
      loss_cnt_r <= '0;
      opt_present_r <= 1'b1;
    end else if (loss_cnt_r == 6'(`CRSRC_LOSS_CYC - 1)) begin
      opt_present_r <= 1'b0;
    end else begin
      loss_cnt_r <= loss_cnt_r + 6'h1;
    end
  end

  assign o_dig_lamp = dig_sel_r && (opt_present_r || flash_r);

  // Record data per track: optical via map when digital is selected, else analog.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rec_data_r <= '0;
    end else begin
      for (int t = 0; t < N; t++) begin
        if (dig_sel_r) begin
          rec_data_r[t] <= silent[t] ? 1'b0 : odat_s2_r[route[t*3 +: 3]];
        end else begin
          rec_data_r[t] <= i_ana_data[t];
        end
      end
    end
  end
  assign o_rec_data = rec_data_r;

  // Each check below watches state or outputs that this controller drives.
  nolock_norec_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_sample_lock |-> o_rec_en == '0) else $error("record without lock");
  syncloss_drop_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_master_sync |-> o_rec_en == '0) else $error("record after sync loss");
  punch_defer_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_CHASE |-> !o_xport.format && !o_xport.extend) else $error("punch early");
  full_rewind_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_IDLE && i_master.go && !i_master.stop && i_master.cmd == CRSRC_CMD_FULL
    |=> state_r == CRSRC_REWIND) else $error("full format no rewind");
  full_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_IDLE && i_master.go && !i_master.stop && i_master.cmd == CRSRC_CMD_FULL
    |=> full_pass_r) else $error("full pass not marked");
  nofmt_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_IDLE && i_master.go && !i_master.stop && !fmt_arm_r && !i_tape_formatted
    |=> no_fmt_r) else $error("no-format code missing");
  unfmt_extend_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_IDLE && i_master.go && !i_master.stop && i_master.cmd == CRSRC_CMD_EXTEND
    && !i_tape_formatted |=> state_r == CRSRC_RUN && no_fmt_r) else $error("extend unfmt");
  extend_locate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_IDLE && i_master.go && !i_master.stop && i_master.cmd == CRSRC_CMD_EXTEND
    && i_tape_formatted && fmt_arm_r |=> state_r == CRSRC_LOCATE && plan_r.extend)
    else $error("extend not planned");
  rewind_done_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_REWIND && i_at_position && !i_master.stop |=> state_r == CRSRC_CHASE)
    else $error("no chase after rewind");
  locate_done_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state_r == CRSRC_LOCATE && i_at_position && !i_master.stop |=> state_r == CRSRC_CHASE)
    else $error("no chase after locate");
  map_frozen_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    rec_allow && $past(rec_allow) |-> $stable(frz_src_r) && $stable(frz_arm_r))
    else $error("map changed mid pass");
  analog_ignored_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    dig_sel_r && $past(dig_sel_r) && silent == '1 |=> rec_data_r == '0)
    else $error("analog leaked");
  dig_flash_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    dig_sel_r && !opt_present_r |-> o_dig_lamp == flash_r) else $error("dig lamp");
  // A front-panel write must land even when the remote writes in the same cycle.
  panel_wins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    apb_wr && i_paddr == `CRSRC_ADDR_SRCSEL
    |=> src_sel_r == N'($past(i_pwdata)) && fp_src_r) else $error("panel routing lost");

  full_pass_c: cover property (@(posedge i_clk)
    state_r == CRSRC_REWIND ##[1:20] state_r == CRSRC_RUN);
  extend_c: cover property (@(posedge i_clk) o_xport.extend);
  record_c: cover property (@(posedge i_clk) o_rec_en != '0);
  silence_c: cover property (@(posedge i_clk) dig_sel_r && silent != '0);
  nofmt_c: cover property (@(posedge i_clk) no_fmt_r && o_fmt_lamp);
endmodule : crsrc_ctrl

// ==== tb/crsrc_master_model.sv ====
// Behavioural model of the master recorder on the sync cable and optical bus.
`timescale 1ns/100ps
module crsrc_master_model
  import crsrc_pkg::*;
(
  // Clock.
  input wire logic i_clk,
  // Sync cable.
  output crsrc_master_s o_master,
  output logic o_master_sync,
  // Optical bus.
  output logic o_opt_clk,
  output logic [7:0] o_opt_data
);
  logic link_on = 1'b0;
  logic [7:0] word = 8'h00;
  initial begin
    o_master = '0;
    o_master_sync = 1'b0;
    o_opt_clk = 1'b0;
    o_opt_data = 8'h00;
  end
  // With the link off the word clock stands still and the released bus keeps changing.
  always begin
    #160;
    if (link_on) begin
      o_opt_clk = ~o_opt_clk;
      if (!o_opt_clk) o_opt_data = word;
    end else begin
      o_opt_clk = 1'b0;
      o_opt_data = ~o_opt_data;
    end
  end
  // The master is in sync one cycle before it commands any pass.
  task automatic issue(input crsrc_cmd_e cmd, input logic at_start);
    @(posedge i_clk);
    o_master_sync <= 1'b1;
    @(posedge i_clk);
    o_master.cmd <= cmd;
    o_master.at_start <= at_start;
    o_master.go <= 1'b1;
    @(posedge i_clk);
    o_master.go <= 1'b0;
  endtask : issue
  task automatic halt();
    @(posedge i_clk);
    o_master.stop <= 1'b1;
    @(posedge i_clk);
    o_master.stop <= 1'b0;
  endtask : halt
  task automatic set_sync(input logic v);
    @(posedge i_clk);
    o_master_sync <= v;
  endtask : set_sync
  task automatic set_link(input logic on, input logic [7:0] w);
    link_on = on;
    word = w;
  endtask : set_link
endmodule : crsrc_master_model

// ==== tb/crsrc_ctrl_tb_top.sv ====
// Self-checking testbench of the slave record controller.
`timescale 1ns/100ps
`include "crsrc_regs.svh"
module crsrc_ctrl_tb_top
  import crsrc_pkg::*;
;
  typedef struct packed {
    crsrc_cmd_e cmd;
    logic at_start;
    logic fmt_arm;
    logic fmt;
    logic [1:0] exp_rl;
    logic [2:0] exp_fen;
  } crsrc_row_s;
  // Columns: command, from start, arm, formatted, {rewind,locate}, {format,extend,no-format}.
  crsrc_row_s rows [12] = '{
    '{CRSRC_CMD_FULL, 1'b1, 1'b1, 1'b0, 2'b10, 3'b100},
    '{CRSRC_CMD_FULL, 1'b1, 1'b0, 1'b0, 2'b10, 3'b001},
    '{CRSRC_CMD_FULL, 1'b1, 1'b1, 1'b1, 2'b10, 3'b100},
    '{CRSRC_CMD_FULL, 1'b1, 1'b0, 1'b1, 2'b10, 3'b000},
    '{CRSRC_CMD_EXTEND, 1'b0, 1'b1, 1'b0, 2'b00, 3'b001},
    '{CRSRC_CMD_EXTEND, 1'b0, 1'b1, 1'b1, 2'b01, 3'b010},
    '{CRSRC_CMD_EXTEND, 1'b0, 1'b0, 1'b1, 2'b01, 3'b000},
    '{CRSRC_CMD_RECORD, 1'b0, 1'b0, 1'b0, 2'b00, 3'b001},
    '{CRSRC_CMD_RECORD, 1'b0, 1'b0, 1'b1, 2'b01, 3'b000},
    '{CRSRC_CMD_RECORD, 1'b0, 1'b1, 1'b1, 2'b01, 3'b010},
    '{CRSRC_CMD_RECORD, 1'b1, 1'b1, 1'b1, 2'b10, 3'b100},
    '{CRSRC_CMD_RECORD, 1'b1, 1'b1, 1'b0, 2'b10, 3'b100}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, q;
  logic pready, fmt_lamp, dig_lamp, opt_clk, sync, saw0, saw1;
  logic perr, q_err, chase;
  logic tape_fmt = 1'b0;
  logic at_pos = 1'b0;
  logic lock = 1'b0;
  logic rmt_we = 1'b0;
  logic [7:0] rmt_src = 8'h00;
  logic [7:0] ana = 8'hC3;
  logic [7:0] armv = 8'hA5;
  logic [7:0] opt_data, rec_en, lamps, rec_data;
  crsrc_master_s mst;
  crsrc_xport_s xp;
  int failures = 0;
  int tests_run = 0;
  crsrc_master_model mst_u (.i_clk(clk), .o_master(mst), .o_master_sync(sync),
    .o_opt_clk(opt_clk), .o_opt_data(opt_data));
  crsrc_ctrl #(.N(8), .FLASH_CYC(4)) dut_u (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_master(mst),
    .i_master_sync(sync), .i_tape_formatted(tape_fmt), .i_at_position(at_pos),
    .i_sample_lock(lock), .i_rmt_we(rmt_we), .i_rmt_src(rmt_src), .i_opt_clk(opt_clk),
    .i_opt_data(opt_data), .i_ana_data(ana), .o_xport(xp), .o_fmt_lamp(fmt_lamp),
    .o_dig_lamp(dig_lamp), .o_chase_lamp(chase), .o_rec_en(rec_en),
    .o_source_channel_lamps(lamps), .o_rec_data(rec_data));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    q_err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic seen(ref logic s);
    saw0 = 1'b0;
    saw1 = 1'b0;
    repeat (24) begin
      @(negedge clk);
      saw0 |= !s;
      saw1 |= s;
    end
  endtask : seen
  // Drives one pass from the master command up to sample-lock.
  task automatic run(input crsrc_row_s r, input logic optical_clock_source);
    apb(1'b1, `CRSRC_ADDR_CTRL, {30'h0, optical_clock_source, r.fmt_arm});
    tape_fmt <= r.fmt;
    mst_u.issue(r.cmd, r.at_start);
    @(negedge clk);
    chk(32'({xp.rewind, xp.locate}), 32'(r.exp_rl), "first move");
    @(posedge clk);
    at_pos <= 1'b1;
    cyc(3);
    chk(32'(rec_en), 32'h0, "record before lock");
    chk(32'({chase, xp.play}), (r.exp_rl == 2'b00) ? 32'h1 : 32'h3, "chase and play");
    @(posedge clk);
    lock <= 1'b1;
    cyc(3);
    chk(32'({xp.format, xp.extend, xp.no_fmt_code}), 32'(r.exp_fen), "pass kind");
    chk(32'(rec_en), r.exp_fen[0] ? 32'h0 : 32'(armv), "armed tracks");
    if (r.exp_fen[0]) begin
      seen(fmt_lamp);
      chk(32'({saw0, saw1}), 32'h3, "format lamp");
    end
  endtask : run
  task automatic stop_run();
    mst_u.halt();
    at_pos <= 1'b0;
    lock <= 1'b0;
    cyc(2);
  endtask : stop_run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'({lamps, rec_en}), 32'h0000FF00, "reset outputs");
    apb(1'b0, `CRSRC_ADDR_SRCSEL, 32'h0);
    chk(q, 32'h000000FF, "source select reset");
    apb(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0, "unmapped read");
    chk(32'(q_err), 32'h0, "no error response");
    apb(1'b1, `CRSRC_ADDR_ARM, 32'(armv));
    foreach (rows[i]) begin
      run(rows[i], 1'b0);
      stop_run();
      $display("row %0d done", i);
    end
    chk(32'(rec_data), 32'(ana), "analog path");
    run(rows[2], 1'b0);
    mst_u.set_sync(1'b0);
    cyc(2);
    chk(32'(rec_en), 32'h0, "record after sync loss");
    stop_run();
    $display("sync loss test done");
    apb(1'b1, `CRSRC_ADDR_SRCSEL, 32'h11);
    apb(1'b1, `CRSRC_ADDR_ARM, 32'hCC);
    apb(1'b0, `CRSRC_ADDR_ROUTE, 32'h0);
    chk(q & 32'h00FC0FC0, 32'h00800800, "cyclic route");
    armv = 8'hFF;
    apb(1'b1, `CRSRC_ADDR_SRCSEL, 32'hFF);
    apb(1'b1, `CRSRC_ADDR_ARM, 32'(armv));
    apb(1'b0, `CRSRC_ADDR_ROUTE, 32'h0);
    chk(q, 32'h00FAC688, "identity route");
    $display("route test done");
    mst_u.set_link(1'b1, 8'h3C);
    run(rows[9], 1'b1);
    cyc(30);
    chk(32'(rec_data), 32'h3C, "optical data");
    apb(1'b1, `CRSRC_ADDR_SRCSEL, 32'h0);
    cyc(30);
    chk(32'(rec_data), 32'h3C, "map held in pass");
    apb(1'b0, `CRSRC_ADDR_STATUS, 32'h0);
    chk(32'(q[7]), 32'h1, "optical present");
    stop_run();
    run(rows[9], 1'b1);
    cyc(30);
    chk(32'(rec_data), 32'h0, "silence");
    mst_u.set_link(1'b0, 8'h00);
    cyc(50);
    seen(dig_lamp);
    chk(32'({saw0, saw1}), 32'h3, "digital lamp");
    stop_run();
    $display("digital test done");
    @(posedge clk);
    rmt_we <= 1'b1;
    rmt_src <= 8'h5A;
    @(posedge clk);
    rmt_we <= 1'b0;
    cyc(2);
    chk(32'(lamps), 32'h5A, "remote route");
    apb(1'b1, `CRSRC_ADDR_SRCSEL, 32'h0F);
    apb(1'b0, `CRSRC_ADDR_CTRL, 32'h0);
    chk(32'({q[2], lamps}), 32'h10F, "panel over remote");
    $display("panel test done");
    run(rows[0], 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    at_pos <= 1'b0;
    lock <= 1'b0;
    @(negedge clk);
    chk(32'({lamps, rec_en, xp}), 32'h003FC000, "outputs after reset");
    apb(1'b0, `CRSRC_ADDR_CTRL, 32'h0);
    chk(q, 32'h0, "control after reset");
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule : crsrc_ctrl_tb_top
